// ### hdl/ftcm_monitor.sv
// fan tachometer count monitor, channel 1: counter, threshold and current count
// What this block does
// - Raise fan interrupt when the counter goes above the threshold register.
// - Current count holds a count only while enabled; host may only read it.
// - Count ticks scale so RPM equals 1,200,000 over count times divisor.
// - No valid count until one full revolution after enable or clear.
// - Count 00h means no revolution has completed since counting began.
// - Count FFh means fan very slow or tach pulses missing.
// - Polled mode: current count refreshes once every revolution.
// - Interrupt mode: refresh each revolution until interrupt, then freeze.
// - Clearing the interrupt zeroes the current count and restarts measuring.
// - Threshold and current count are eight bits and reset to zero.
// - Enabled tach pulses gate a 20 kHz reference; two pulses per revolution.
// - Divisor select 00,01,10,11 gives divide by 1,2,4,8.
// - Interrupt only when enabled; drives low interrupt and source address.
`timescale 1ns/10ps
module ftcm_monitor
  import ftcm_pkg::*;
#(
  parameter int REF_CYCLES = FTCM_REF_CYCLES
)
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic TACH_INPUT_PIN,
  input wire ftcm_ctrl_t CTRL,
  input wire logic IRQ_CLEAR,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic [7:0] THRESHOLD_VALUE,
  output logic [7:0] CURRENT_COUNT,
  output logic FAN_IRQ_N,
  output logic [7:0] IRQ_SOURCE_ADDR
);

  // elaboration guard: the prescaler is 16 bits, and fewer than three clocks a
  // reference period would let ticks fall closer than the gap check expects
  if (REF_CYCLES < 3 || REF_CYCLES > 65535)
  begin : g_ref_cycles_bad
    $error("REF_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic tach_s1_reg, tach_s2_reg, tach_d_reg;
  logic [15:0] pre_reg, pre_next;
  logic [3:0] div_reg, div_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] thr_reg, thr_next;
  logic [7:0] cur_reg, cur_next;
  logic pend_reg, pend_next;
  logic [7:0] src_reg, src_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_n_reg, irq_n_next;
  ftcm_state_t st_reg, st_next;

  ////////////////////////////////////////////////////////////////////////////
  // tach pin synchroniser; first stage feeds only the second
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      tach_s1_reg <= 1'b0;
      tach_s2_reg <= 1'b0;
      tach_d_reg <= 1'b0;
    end
    else
    begin
      tach_s1_reg <= TACH_INPUT_PIN;
      tach_s2_reg <= tach_s1_reg;
      tach_d_reg <= tach_s2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic enabled = CTRL.fan_monitor_enable;
  wire logic restart = ~enabled | IRQ_CLEAR; // disable or clear starts over
  wire logic tach_rise = tach_s2_reg & ~tach_d_reg;
  wire logic [3:0] div_val = (CTRL.divisor_select == FTCM_DIV_SEL_1) ? FTCM_DIV_1 :
    (CTRL.divisor_select == FTCM_DIV_SEL_2) ? FTCM_DIV_2 :
    (CTRL.divisor_select == FTCM_DIV_SEL_4) ? FTCM_DIV_4 : FTCM_DIV_8;
  wire logic pre_wrap = (pre_reg == 16'(REF_CYCLES - 1)); // one 20 kHz period
  wire logic div_wrap = (div_reg >= div_val - 4'h1);
  wire logic tick = pre_wrap & div_wrap;
  wire logic rev_done = tach_rise & (st_reg == FTCM_ST_HALF2);
  wire logic cnt_clr = tach_rise & (st_reg != FTCM_ST_HALF1);
  wire logic cnt_inc = enabled & ~restart & ~cnt_clr & tick &
    (cnt_reg != FTCM_COUNT_MAX);
  wire logic over_evt = cnt_inc & (cnt_reg == thr_reg) & CTRL.fan_irq_enable;
  wire logic frozen = pend_reg;
  wire logic wr_thr = REG_WR & (REG_ADDR == FTCM_OFS_THRESHOLD);

  ////////////////////////////////////////////////////////////////////////////
  // reference prescaler and divisor stage
  assign pre_next = (restart | pre_wrap) ? 16'h0000 : pre_reg + 16'h0001;
  assign div_next = (restart | div_wrap & pre_wrap) ? 4'h0 :
    pre_wrap ? div_reg + 4'h1 : div_reg;

  // revolution counter: zero at each revolution start, stops at FFh
  assign cnt_next = (restart | cnt_clr) ? FTCM_COUNT_NONE :
    cnt_inc ? cnt_reg + 8'h01 : cnt_reg;

  // phase sequencing: first pulse starts, two more pulses end a revolution
  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg)
      FTCM_ST_OFF: st_next = enabled ? FTCM_ST_WAIT : FTCM_ST_OFF;
      FTCM_ST_WAIT: st_next = tach_rise ? FTCM_ST_HALF1 : FTCM_ST_WAIT;
      FTCM_ST_HALF1: st_next = tach_rise ? FTCM_ST_HALF2 : FTCM_ST_HALF1;
      FTCM_ST_HALF2: st_next = tach_rise ? FTCM_ST_HALF1 : FTCM_ST_HALF2;
    endcase
    if (restart)
      st_next = enabled ? FTCM_ST_WAIT : FTCM_ST_OFF;
  end

  // current count publish; a fast fan still shows 01h so 00h stays "no data"
  assign cur_next = restart ? FTCM_CURRENT_RST :
    frozen ? cur_reg :
    rev_done ? ((cnt_reg == FTCM_COUNT_NONE) ? FTCM_COUNT_MIN : cnt_reg) :
    (cnt_reg == FTCM_COUNT_MAX) ? FTCM_COUNT_MAX : cur_reg;

  // interrupt flag: a coincident clear wins, since clear blocks the count step that makes an event
  assign pend_next = over_evt | (pend_reg & ~IRQ_CLEAR);
  assign src_next = over_evt ? FTCM_OFS_CONTROL : pend_next ? src_reg : FTCM_SRC_NONE;
  assign irq_n_next = ~pend_next;

  // threshold is host writable; the current count ignores writes
  assign thr_next = wr_thr ? REG_WDATA : thr_reg;
  assign rdata_next = (REG_ADDR == FTCM_OFS_THRESHOLD) ? thr_reg :
    (REG_ADDR == FTCM_OFS_CURRENT) ? cur_reg : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      pre_reg <= 16'h0000;
      div_reg <= 4'h0;
      cnt_reg <= FTCM_COUNT_NONE;
      st_reg <= FTCM_ST_OFF;
    end
    else
    begin
      pre_reg <= pre_next;
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      st_reg <= st_next;
    end
  end

  // host-visible state, reset to zero except the interrupt pin flop, which resets high
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      thr_reg <= FTCM_THRESHOLD_RST;
      cur_reg <= FTCM_CURRENT_RST;
      pend_reg <= 1'b0;
      src_reg <= FTCM_SRC_NONE;
      rdata_reg <= 8'h00;
      irq_n_reg <= 1'b1;
    end
    else
    begin
      thr_reg <= thr_next;
      cur_reg <= cur_next;
      pend_reg <= pend_next;
      src_reg <= src_next;
      rdata_reg <= rdata_next;
      irq_n_reg <= irq_n_next;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign THRESHOLD_VALUE = thr_reg;
  assign CURRENT_COUNT = cur_reg;
  assign FAN_IRQ_N = irq_n_reg; // own flop, so no gate glitch reaches the pin
  assign IRQ_SOURCE_ADDR = src_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  sequence rev_end_s;
    tach_rise && st_reg == FTCM_ST_HALF2 && enabled && !IRQ_CLEAR;
  endsequence

  sequence unfrozen_s;
    !pend_reg;
  endsequence

  over_thr_irq_a: assert property (over_evt |=> !FAN_IRQ_N && cnt_reg > thr_reg)
    else $error("interrupt not raised over threshold");
  disabled_zero_a: assert property (!enabled |=> CURRENT_COUNT == FTCM_CURRENT_RST)
    else $error("count not zero while disabled");
  no_irq_dis_a: assert property (!CTRL.fan_irq_enable && !pend_reg |=> FAN_IRQ_N)
    else $error("interrupt raised while disabled");
  src_addr_a: assert property ($fell(FAN_IRQ_N) |-> IRQ_SOURCE_ADDR == FTCM_OFS_CONTROL)
    else $error("source address not loaded");
  poll_refresh_a: assert property (rev_end_s and unfrozen_s |=>
      CURRENT_COUNT == (($past(cnt_reg) == FTCM_COUNT_NONE) ? FTCM_COUNT_MIN : $past(cnt_reg)))
    else $error("count not refreshed at revolution");
  frozen_hold_a: assert property (pend_reg && !IRQ_CLEAR && enabled |=>
      $stable(CURRENT_COUNT))
    else $error("count changed while frozen");
  clear_zero_a: assert property (IRQ_CLEAR |=>
      CURRENT_COUNT == FTCM_CURRENT_RST && cnt_reg == FTCM_COUNT_NONE)
    else $error("clear did not zero count");
  sat_hold_a: assert property (cnt_reg == FTCM_COUNT_MAX && !cnt_clr && !restart |=>
      cnt_reg == FTCM_COUNT_MAX)
    else $error("counter wrapped");
  // before the first pulse of the first revolution only "no data" or "stalled" may show
  first_rev_a: assert property (st_reg == FTCM_ST_WAIT |=>
      CURRENT_COUNT == FTCM_COUNT_NONE || CURRENT_COUNT == FTCM_COUNT_MAX)
    else $error("count published before a revolution");
  thr_write_a: assert property (wr_thr |=> THRESHOLD_VALUE == $past(REG_WDATA))
    else $error("threshold write lost");
  read_current_a: assert property (REG_ADDR == FTCM_OFS_CURRENT |=>
      REG_RDATA == $past(CURRENT_COUNT))
    else $error("current count read mismatch");
  tick_gap_a: assert property (tick && enabled && !restart |=> !tick [*2])
    else $error("reference ticks too close");
endmodule : ftcm_monitor

// ### hdl/ftcm_pkg.sv
// constants and carrier types for the fan tach count monitor, channel 1
package ftcm_pkg;
  // register offsets on the serial register port
  localparam logic [7:0] FTCM_OFS_CONTROL = 8'h34;
  localparam logic [7:0] FTCM_OFS_THRESHOLD = 8'h35;
  localparam logic [7:0] FTCM_OFS_CURRENT = 8'h36;
  // reset values
  localparam logic [7:0] FTCM_THRESHOLD_RST = 8'h00;
  localparam logic [7:0] FTCM_CURRENT_RST = 8'h00;
  localparam logic [7:0] FTCM_SRC_NONE = 8'h00;
  // special count values
  localparam logic [7:0] FTCM_COUNT_NONE = 8'h00;
  localparam logic [7:0] FTCM_COUNT_MIN = 8'h01;
  localparam logic [7:0] FTCM_COUNT_MAX = 8'hFF;
  // timing: system clock and reference clock
  localparam int FTCM_CLK_HZ = 50000000;
  localparam int FTCM_REF_HZ = 20000;
  localparam int FTCM_REF_CYCLES = FTCM_CLK_HZ / FTCM_REF_HZ;
  // divisor select codes and their divide values
  localparam logic [1:0] FTCM_DIV_SEL_1 = 2'h0;
  localparam logic [1:0] FTCM_DIV_SEL_2 = 2'h1;
  localparam logic [1:0] FTCM_DIV_SEL_4 = 2'h2;
  localparam logic [1:0] FTCM_DIV_SEL_8 = 2'h3;
  localparam logic [3:0] FTCM_DIV_1 = 4'h1;
  localparam logic [3:0] FTCM_DIV_2 = 4'h2;
  localparam logic [3:0] FTCM_DIV_4 = 4'h4;
  localparam logic [3:0] FTCM_DIV_8 = 4'h8;

  // control bits handed in from the channel control register
  typedef struct packed {
    logic fan_monitor_enable;
    logic fan_irq_enable;
    logic [1:0] divisor_select;
  } ftcm_ctrl_t;

  // measurement phase across one revolution (two tach pulses)
  typedef enum logic [1:0] {
    FTCM_ST_OFF = 2'b00,
    FTCM_ST_WAIT = 2'b01,
    FTCM_ST_HALF1 = 2'b10,
    FTCM_ST_HALF2 = 2'b11
  } ftcm_state_t;
endpackage : ftcm_pkg

// ### sim/ftcm_fan_model.sv
// fan tachometer model: two pulses per revolution, can stall
`timescale 1ns/10ps
module ftcm_fan_model
(
  input wire logic clk,
  input wire logic run,
  input wire logic [15:0] half_rev,
  output logic tach
);
  logic [15:0] cnt_reg;
  initial cnt_reg = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////
  // one pulse each half revolution; a stalled fan leaves the pin low
  always @(posedge clk)
  begin
    if (!run || cnt_reg >= half_rev - 16'h0001)
      cnt_reg <= 16'h0000;
    else
      cnt_reg <= cnt_reg + 16'h0001;
  end
  // pulse kept long enough to pass the input synchroniser
  assign tach = run && (cnt_reg < 16'h0008);
endmodule : ftcm_fan_model

// ### sim/fan_tach_count_monitor_ch1_tb.sv
// self-checking bench for the fan tach count monitor, channel 1
`timescale 1ns/10ps
module fan_tach_count_monitor_ch1_tb
  import ftcm_pkg::*;
;
  logic clk, sys_rst, tach, irq_clear, reg_wr, run, irq_n;
  ftcm_ctrl_t ctrl;
  logic [7:0] reg_addr, reg_wdata, rdata, thr, cur, src, v;
  int failures = 0;
  int compares = 0;
  ftcm_monitor #(.REF_CYCLES(4)) ftcm_monitor_inst (.CLK(clk), .SYS_RST(sys_rst),
    .TACH_INPUT_PIN(tach), .CTRL(ctrl), .IRQ_CLEAR(irq_clear), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .THRESHOLD_VALUE(thr),
    .CURRENT_COUNT(cur), .FAN_IRQ_N(irq_n), .IRQ_SOURCE_ADDR(src));
  // 320 clocks a revolution: 80 ticks at divide by one
  ftcm_fan_model ftcm_fan_model_inst (.clk(clk), .run(run), .half_rev(16'h00A0),
    .tach(tach));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask : wr
  // read data is registered; the address is held two full cycles before sampling
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    cyc(2);
    d = rdata;
  endtask : rd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // tick phase against the tach edges makes counts vary by one
  task automatic chk_rng(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if ($isunknown(got) || got + 8'h01 < exp || got > exp + 8'h01)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_rng
  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  // watchdog sized well above the roughly 8000 cycles of the tests
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {sys_rst, irq_clear, reg_wr, run, reg_addr, reg_wdata} = {4'h8, 16'h0000};
    ctrl = '0;
    cyc(20);
    sys_rst = 1'b0;
    rd(FTCM_OFS_THRESHOLD, v);
    chk(v, FTCM_THRESHOLD_RST);
    rd(FTCM_OFS_CURRENT, v);
    chk(v, FTCM_CURRENT_RST);
    wr(FTCM_OFS_CURRENT, 8'h5A);
    rd(FTCM_OFS_CURRENT, v);
    chk(v, 8'h00);
    wr(FTCM_OFS_THRESHOLD, 8'h30);
    rd(FTCM_OFS_THRESHOLD, v);
    chk(v, 8'h30);
    chk(thr, 8'h30);
    run = 1'b1;
    // polled mode through every divisor code
    for (int i = 0; i < 4; i++)
    begin
      ctrl = '0;
      cyc(2);
      ctrl = {1'b1, 1'b0, i[1:0]};
      cyc(4);
      chk(cur, FTCM_COUNT_NONE);
      cyc(980);
      chk_rng(cur, 8'h50 >> i);
      rd(FTCM_OFS_CURRENT, v);
      chk_rng(v, 8'h50 >> i);
      // a host write while counting must not land in the count
      wr(FTCM_OFS_CURRENT, 8'h5A);
      chk_rng(cur, 8'h50 >> i);
      chk({7'h00, irq_n}, 8'h01);
    end
    // stalled fan: counter must pin at full scale
    ctrl = {1'b1, 1'b0, FTCM_DIV_SEL_1};
    run = 1'b0;
    cyc(1200);
    chk(cur, FTCM_COUNT_MAX);
    run = 1'b1;
    cyc(700);
    ctrl.fan_irq_enable = 1'b1;
    for (int n = 0; n < 800 && irq_n !== 1'b0; n++)
      cyc(1);
    v = cur;
    chk_rng(v, 8'h50);
    chk({7'h00, irq_n}, 8'h00);
    chk(src, FTCM_OFS_CONTROL);
    cyc(1000);
    chk(cur, v);
    ctrl.fan_irq_enable = 1'b0;
    irq_clear = 1'b1;
    cyc(1);
    irq_clear = 1'b0;
    chk(cur, FTCM_COUNT_NONE);
    chk({7'h00, irq_n}, 8'h01);
    chk(src, FTCM_SRC_NONE);
    cyc(700);
    chk_rng(cur, 8'h50);
    // second reset in mid-run: both registers and the pin return to idle
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    chk(thr, FTCM_THRESHOLD_RST);
    chk(cur, FTCM_CURRENT_RST);
    chk({7'h00, irq_n}, 8'h01);
    final_report();
  end
endmodule : fan_tach_count_monitor_ch1_tb
